//--- rtl/epa_event_regs.svh
// Event numbers, priority groups and rank table entries of the event arbiter
`ifndef EPA_EVENT_REGS_SVH
`define EPA_EVENT_REGS_SVH

// Event count and width of an event number
`define EPA_NUM_EVENTS   34
`define EPA_EVENT_W      6
`define EPA_EDGE_LINES   4
`define EPA_TIE_CLASS_N  3

// Priority group codes, lower wins
`define EPA_GRP_COMM     2'h0
`define EPA_GRP_DISC     2'h1
`define EPA_GRP_TIME     2'h2

// Event numbers by source
`define EPA_EV_LINE_RISE0    0
`define EPA_EV_LINE_FALL0    1
`define EPA_EV_SP0_RXCHAR    8
`define EPA_EV_SP0_TXDONE    9
`define EPA_EV_PERIODIC0     10
`define EPA_EV_PERIODIC1     11
`define EPA_EV_FC0_MATCH     12
`define EPA_EV_FC1_MATCH     13
`define EPA_EV_FC1_DIR       14
`define EPA_EV_FC1_EXTRST    15
`define EPA_EV_FC2_MATCH     16
`define EPA_EV_FC2_DIR       17
`define EPA_EV_FC2_EXTRST    18
`define EPA_EV_PTO0_DONE     19
`define EPA_EV_PTO1_DONE     20
`define EPA_EV_TMRA_MATCH    21
`define EPA_EV_TMRB_MATCH    22
`define EPA_EV_SP0_RXMSG     23
`define EPA_EV_SP1_RXMSG     24
`define EPA_EV_SP1_RXCHAR    25
`define EPA_EV_SP1_TXDONE    26
`define EPA_EV_FC0_DIR       27
`define EPA_EV_FC0_EXTRST    28
`define EPA_EV_FC4_MATCH     29
`define EPA_EV_FC4_DIR       30
`define EPA_EV_FC4_EXTRST    31
`define EPA_EV_FC3_MATCH     32
`define EPA_EV_FC5_MATCH     33

// In-group levels that are not simply an event offset
`define EPA_LVL_LINE_RISE0   5'h02
`define EPA_LVL_LINE_FALL0   5'h06

`endif

//--- rtl/epa_pkg.sv
// Types and rank table of the event priority arbiter
`include "epa_event_regs.svh"
package epa_pkg;
    typedef logic [`EPA_EVENT_W-1:0] epa_event_t;
    typedef logic [1:0]              epa_group_t;
    typedef logic [4:0]              epa_level_t;
    typedef struct packed {
        epa_group_t grp;
        epa_level_t lvl;
    } epa_rank_t;
    typedef enum logic [0:0] {GS_IDLE, GS_OFFER} epa_gstate_t;

    // Rank of every event, indexed by event number
    localparam epa_rank_t EPA_RANK_TABLE [`EPA_NUM_EVENTS] = '{
        '{`EPA_GRP_DISC, 5'h02}, '{`EPA_GRP_DISC, 5'h06}, '{`EPA_GRP_DISC, 5'h03},
        '{`EPA_GRP_DISC, 5'h07}, '{`EPA_GRP_DISC, 5'h04}, '{`EPA_GRP_DISC, 5'h08},
        '{`EPA_GRP_DISC, 5'h05}, '{`EPA_GRP_DISC, 5'h09}, '{`EPA_GRP_COMM, 5'h00},
        '{`EPA_GRP_COMM, 5'h00}, '{`EPA_GRP_TIME, 5'h00}, '{`EPA_GRP_TIME, 5'h01},
        '{`EPA_GRP_DISC, 5'h0A}, '{`EPA_GRP_DISC, 5'h0D}, '{`EPA_GRP_DISC, 5'h0E},
        '{`EPA_GRP_DISC, 5'h0F}, '{`EPA_GRP_DISC, 5'h10}, '{`EPA_GRP_DISC, 5'h11},
        '{`EPA_GRP_DISC, 5'h12}, '{`EPA_GRP_DISC, 5'h00}, '{`EPA_GRP_DISC, 5'h01},
        '{`EPA_GRP_TIME, 5'h02}, '{`EPA_GRP_TIME, 5'h03}, '{`EPA_GRP_COMM, 5'h00},
        '{`EPA_GRP_COMM, 5'h01}, '{`EPA_GRP_COMM, 5'h01}, '{`EPA_GRP_COMM, 5'h01},
        '{`EPA_GRP_DISC, 5'h0B}, '{`EPA_GRP_DISC, 5'h0C}, '{`EPA_GRP_DISC, 5'h14},
        '{`EPA_GRP_DISC, 5'h15}, '{`EPA_GRP_DISC, 5'h16}, '{`EPA_GRP_DISC, 5'h13},
        '{`EPA_GRP_DISC, 5'h17}
    };
endpackage

//--- rtl/epa_age_matrix.sv
// Arrival-order tracker for events that share one rank
`timescale 1ns/1ps
module epa_age_matrix
    import epa_pkg::*;
#(
    parameter int N = `EPA_TIE_CLASS_N
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Pending state and fresh arrivals
    input  wire logic [N-1:0] pendFlags,
    input  wire logic [N-1:0] newArrival,
    // Oldest pending member, one-hot
    output logic      [N-1:0] headFlags
);
    // olderReg[i][j] set means member i arrived before member j
    logic [N-1:0] olderReg [N];

    // A fresh arrival becomes the youngest; same-cycle ties go to the lower index
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                olderReg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                for (int j = 0; j < N; j++) begin
                    if (i != j) begin
                        if (newArrival[i] && newArrival[j]) begin
                            olderReg[i][j] <= (i < j);
                        end else if (newArrival[i]) begin
                            olderReg[i][j] <= 1'b0;
                        end else if (newArrival[j]) begin
                            olderReg[i][j] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Stale bits of idle members are harmless, pendFlags masks them
    always_comb begin
        headFlags = '0;
        for (int i = 0; i < N; i++) begin
            headFlags[i] = pendFlags[i];
            for (int j = 0; j < N; j++) begin
                if (j != i && pendFlags[j] && olderReg[j][i]) begin
                    headFlags[i] = 1'b0;
                end
            end
        end
    end
endmodule

//--- rtl/epa_rank_select.sv
// Combinational pick of the best-ranked eligible event
`timescale 1ns/1ps
module epa_rank_select
    import epa_pkg::*;
(
    // Candidates by event number
    input  wire logic [`EPA_NUM_EVENTS-1:0] eligible,
    // Winner
    output logic                            selFound,
    output epa_event_t                      selEvent,
    output epa_rank_t                       selRank
);
    // Strict compare keeps the lowest event number on an equal rank
    always_comb begin
        selFound = 1'b0;
        selEvent = '0;
        selRank  = '0;
        for (int i = 0; i < `EPA_NUM_EVENTS; i++) begin
            if (eligible[i] && (!selFound || EPA_RANK_TABLE[i] < selRank)) begin
                selFound = 1'b1;
                selEvent = epa_event_t'(i);
                selRank  = EPA_RANK_TABLE[i];
            end
        end
    end
endmodule

//--- rtl/epa_event_arbiter.sv
// Top of the fixed-priority event arbiter: latches, ordering and grant
//
// Functional notes
// R01: Communications beat discrete, discrete beat time-based
// R02: First serial port events 8, 9, 23, level 0
// R03: Second serial port events 24, 25, 26, level 1
// R04: Pulse train done: events 19, 20, levels 0, 1
// R05: Input edges: rise 0,2,4,6 and fall 1,3,5,7
// R06: Counter 0: events 12, 27, 28, levels 10-12
// R07: Counters 1, 2: events 13-18, levels 13-18
// R08: Counter 3 match only: event 32, level 19
// R09: Counter 4: events 29-31, levels 20-22
// R10: Counter 5 match only: event 33, level 23
// R11: Periodic 10, 11; timer A match 21
// R12: Timer B match: event 22, time level 3
// R13: Pending latch per event, cleared on taken grant
// R14: Equal-rank events served in arrival order
`timescale 1ns/1ps
module epa_event_arbiter
    import epa_pkg::*;
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // Serial port 0: receive char, transmit done, receive message
    input  wire logic                        sp0RxChar,
    input  wire logic                        sp0TxDone,
    input  wire logic                        sp0RxMsg,
    // Serial port 1: receive message, receive char, transmit done
    input  wire logic                        sp1RxMsg,
    input  wire logic                        sp1RxChar,
    input  wire logic                        sp1TxDone,
    // Pulse train output channels done
    input  wire logic [1:0]                  pulseTrainDone,
    // Input lines 0 to 3, levels
    input  wire logic [`EPA_EDGE_LINES-1:0]  inputLine,
    // Fast counters: count match, direction change, external reset
    input  wire logic [2:0]                  fastCounter0Evt,
    input  wire logic [2:0]                  fastCounter1Evt,
    input  wire logic [2:0]                  fastCounter2Evt,
    input  wire logic                        fastCounter3Match,
    input  wire logic [2:0]                  fastCounter4Evt,
    input  wire logic                        fastCounter5Match,
    // Periodic ticks and delay timer matches
    input  wire logic [1:0]                  periodicTick,
    input  wire logic                        delayTimerAMatch,
    input  wire logic                        delayTimerBMatch,
    // Processor side
    input  wire logic                        serviceEnable,
    input  wire logic                        grantTake,
    output logic                             grantValid,
    output epa_event_t                       grantEvent,
    output epa_group_t                       grantGroup,
    output epa_level_t                       grantLevel,
    // Status
    output logic [`EPA_NUM_EVENTS-1:0]       pendingFlags,
    output logic                             lostEvent,
    output epa_event_t                       lostEventNum
);

    // Lowest set bit of an event vector
    function automatic epa_event_t firstSet(input logic [`EPA_NUM_EVENTS-1:0] vec);
        epa_event_t idx;
        idx = '0;
        for (int i = `EPA_NUM_EVENTS - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = epa_event_t'(i);
            end
        end
        return idx;
    endfunction

    // Edge detection state
    logic [`EPA_EDGE_LINES-1:0]  lineDelay_reg;
    logic                        linePrimed_reg;
    logic [`EPA_EDGE_LINES-1:0]  lineRise;
    logic [`EPA_EDGE_LINES-1:0]  lineFall;

    // Event and latch state
    logic [`EPA_NUM_EVENTS-1:0]  evtArrive;
    logic [`EPA_NUM_EVENTS-1:0]  pending_reg;
    logic [`EPA_NUM_EVENTS-1:0]  clearVec;
    logic [`EPA_NUM_EVENTS-1:0]  freshVec;
    logic [`EPA_NUM_EVENTS-1:0]  lostVec;
    logic [`EPA_NUM_EVENTS-1:0]  eligible;

    // Equal-rank classes of the two serial ports
    logic [`EPA_TIE_CLASS_N-1:0] sp0Pend;
    logic [`EPA_TIE_CLASS_N-1:0] sp0Fresh;
    logic [`EPA_TIE_CLASS_N-1:0] sp0Head;
    logic [`EPA_TIE_CLASS_N-1:0] sp1Pend;
    logic [`EPA_TIE_CLASS_N-1:0] sp1Fresh;
    logic [`EPA_TIE_CLASS_N-1:0] sp1Head;

    // Selection and grant state
    logic                        selFound;
    epa_event_t                  selEvent;
    epa_rank_t                   selRank;
    logic                        takeOk;
    logic                        offerOk;
    epa_gstate_t                 gstate_reg;
    epa_gstate_t                 gstate_next;
    logic                        grantValid_reg;
    epa_event_t                  grantEvent_reg;
    epa_group_t                  grantGroup_reg;
    epa_level_t                  grantLevel_reg;
    logic                        lostEvent_reg;
    epa_event_t                  lostEventNum_reg;

    // Priming avoids a false rising edge for a line already high at release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lineDelay_reg  <= '0;
            linePrimed_reg <= 1'b0;
        end else begin
            lineDelay_reg  <= inputLine;
            linePrimed_reg <= 1'b1;
        end
    end

    // Edge pulses of the input lines
    assign lineRise = linePrimed_reg ? (inputLine & ~lineDelay_reg) : '0;
    assign lineFall = linePrimed_reg ? (~inputLine & lineDelay_reg) : '0;

    // Sources placed at their event numbers
    always_comb begin
        evtArrive = '0;
        evtArrive[`EPA_EV_SP0_RXCHAR]  = sp0RxChar;         // see R02
        evtArrive[`EPA_EV_SP0_TXDONE]  = sp0TxDone;         // see R02
        evtArrive[`EPA_EV_SP0_RXMSG]   = sp0RxMsg;          // see R02
        evtArrive[`EPA_EV_SP1_RXMSG]   = sp1RxMsg;          // see R03
        evtArrive[`EPA_EV_SP1_RXCHAR]  = sp1RxChar;         // see R03
        evtArrive[`EPA_EV_SP1_TXDONE]  = sp1TxDone;         // see R03
        evtArrive[`EPA_EV_PTO0_DONE]   = pulseTrainDone[0]; // see R04
        evtArrive[`EPA_EV_PTO1_DONE]   = pulseTrainDone[1]; // see R04
        // Rising edges on even numbers, falling on odd
        for (int k = 0; k < `EPA_EDGE_LINES; k++) begin
            evtArrive[`EPA_EV_LINE_RISE0 + 2 * k] = lineRise[k]; // see R05
            evtArrive[`EPA_EV_LINE_FALL0 + 2 * k] = lineFall[k]; // see R05
        end
        evtArrive[`EPA_EV_FC0_MATCH]   = fastCounter0Evt[0]; // see R06
        evtArrive[`EPA_EV_FC0_DIR]     = fastCounter0Evt[1]; // see R06
        evtArrive[`EPA_EV_FC0_EXTRST]  = fastCounter0Evt[2]; // see R06
        evtArrive[`EPA_EV_FC1_MATCH]   = fastCounter1Evt[0]; // see R07
        evtArrive[`EPA_EV_FC1_DIR]     = fastCounter1Evt[1]; // see R07
        evtArrive[`EPA_EV_FC1_EXTRST]  = fastCounter1Evt[2]; // see R07
        evtArrive[`EPA_EV_FC2_MATCH]   = fastCounter2Evt[0]; // see R07
        evtArrive[`EPA_EV_FC2_DIR]     = fastCounter2Evt[1]; // see R07
        evtArrive[`EPA_EV_FC2_EXTRST]  = fastCounter2Evt[2]; // see R07
        evtArrive[`EPA_EV_FC3_MATCH]   = fastCounter3Match;  // see R08
        evtArrive[`EPA_EV_FC4_MATCH]   = fastCounter4Evt[0]; // see R09
        evtArrive[`EPA_EV_FC4_DIR]     = fastCounter4Evt[1]; // see R09
        evtArrive[`EPA_EV_FC4_EXTRST]  = fastCounter4Evt[2]; // see R09
        evtArrive[`EPA_EV_FC5_MATCH]   = fastCounter5Match;  // see R10
        evtArrive[`EPA_EV_PERIODIC0]   = periodicTick[0];    // see R11
        evtArrive[`EPA_EV_PERIODIC1]   = periodicTick[1];    // see R11
        evtArrive[`EPA_EV_TMRA_MATCH]  = delayTimerAMatch;   // see R11
        evtArrive[`EPA_EV_TMRB_MATCH]  = delayTimerBMatch;   // see R12
    end

    // A take is honoured only while an offer stands
    assign takeOk = grantTake && grantValid_reg;

    // One-hot clear of the granted latch
    always_comb begin
        clearVec = '0;
        if (takeOk) begin
            clearVec[grantEvent_reg] = 1'b1; // see R13
        end
    end

    // Fresh means newly pending; a repeat while pending is merged and reported
    assign freshVec = evtArrive & (~pending_reg | clearVec);
    assign lostVec  = evtArrive & pending_reg & ~clearVec;

    // Set wins over clear so an arrival on the take cycle stays pending
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= (pending_reg & ~clearVec) | evtArrive; // see R13
        end
    end

    // Lost-event report, one cycle per cycle of merged repeats, lowest event number kept
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lostEvent_reg    <= 1'b0;
            lostEventNum_reg <= '0;
        end else begin
            lostEvent_reg <= |lostVec;
            if (|lostVec) begin
                lostEventNum_reg <= firstSet(lostVec);
            end
        end
    end

    // Gather the two serial port classes
    assign sp0Pend  = {pending_reg[`EPA_EV_SP0_RXMSG],
                       pending_reg[`EPA_EV_SP0_TXDONE],
                       pending_reg[`EPA_EV_SP0_RXCHAR]};
    assign sp0Fresh = {freshVec[`EPA_EV_SP0_RXMSG],
                       freshVec[`EPA_EV_SP0_TXDONE],
                       freshVec[`EPA_EV_SP0_RXCHAR]};
    assign sp1Pend  = {pending_reg[`EPA_EV_SP1_TXDONE],
                       pending_reg[`EPA_EV_SP1_RXCHAR],
                       pending_reg[`EPA_EV_SP1_RXMSG]};
    assign sp1Fresh = {freshVec[`EPA_EV_SP1_TXDONE],
                       freshVec[`EPA_EV_SP1_RXCHAR],
                       freshVec[`EPA_EV_SP1_RXMSG]};

    // Arrival order of port 0 events
    epa_age_matrix #(
        .N          (`EPA_TIE_CLASS_N)
    ) u_sp0_age (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .pendFlags  (sp0Pend),
        .newArrival (sp0Fresh),
        .headFlags  (sp0Head)
    );

    // Arrival order of port 1 events
    epa_age_matrix #(
        .N          (`EPA_TIE_CLASS_N)
    ) u_sp1_age (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .pendFlags  (sp1Pend),
        .newArrival (sp1Fresh),
        .headFlags  (sp1Head)
    );

    // Only the oldest of an equal-rank class competes
    always_comb begin
        eligible = pending_reg;
        eligible[`EPA_EV_SP0_RXCHAR] = sp0Head[0]; // see R14
        eligible[`EPA_EV_SP0_TXDONE] = sp0Head[1]; // see R14
        eligible[`EPA_EV_SP0_RXMSG]  = sp0Head[2]; // see R14
        eligible[`EPA_EV_SP1_RXMSG]  = sp1Head[0]; // see R14
        eligible[`EPA_EV_SP1_RXCHAR] = sp1Head[1]; // see R14
        eligible[`EPA_EV_SP1_TXDONE] = sp1Head[2]; // see R14
    end

    // Group first, then in-group level, from the rank table
    epa_rank_select u_select (
        .eligible (eligible),
        .selFound (selFound), // see R01
        .selEvent (selEvent),
        .selRank  (selRank)
    );

    // An offer needs a winner and the processor willing to serve
    assign offerOk = selFound && serviceEnable;

    // Grant sequencing; a take always drops the offer for one cycle
    always_comb begin
        gstate_next = gstate_reg;
        unique case (gstate_reg)
            GS_IDLE: begin
                if (offerOk) begin
                    gstate_next = GS_OFFER;
                end
            end
            GS_OFFER: begin
                if (takeOk || !offerOk) begin
                    gstate_next = GS_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gstate_reg <= GS_IDLE;
        end else begin
            gstate_reg <= gstate_next;
        end
    end

    // Offer registers follow the winner, so a better arrival preempts the offer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            grantValid_reg <= 1'b0;
            grantEvent_reg <= '0;
            grantGroup_reg <= '0;
            grantLevel_reg <= '0;
        end else begin
            grantValid_reg <= (gstate_next == GS_OFFER);
            // The gap cycle lets the cleared latch drop out of the selection
            if (offerOk && !takeOk) begin
                grantEvent_reg <= selEvent;     // see R01
                grantGroup_reg <= selRank.grp;
                grantLevel_reg <= selRank.lvl;
            end
        end
    end

    // Outputs straight from flip-flops
    assign grantValid   = grantValid_reg;
    assign grantEvent   = grantEvent_reg;
    assign grantGroup   = grantGroup_reg;
    assign grantLevel   = grantLevel_reg;
    assign pendingFlags = pending_reg;
    assign lostEvent    = lostEvent_reg;
    assign lostEventNum = lostEventNum_reg;
endmodule

//--- tb/epa_proc_model.sv
// Processor model that takes offered grants after a set wait
`timescale 1ns/1ps
module epa_proc_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Grant offer and wait setting
    input  wire logic       grantValid,
    input  wire logic [3:0] waitCycles,
    // Acknowledge
    output logic            grantTake
);
    logic [3:0] waitCnt_reg;

    // Count offer cycles; take is a one-cycle pulse so a take is never doubled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_reg <= 4'h0;
            grantTake   <= 1'b0;
        end else begin
            grantTake   <= grantValid && !grantTake && waitCnt_reg >= waitCycles;
            waitCnt_reg <= (grantValid && !grantTake) ? waitCnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule

//--- tb/epa_event_monitor.sv
// Port-level assertions for the event arbiter
`timescale 1ns/1ps
module epa_event_monitor
    import epa_pkg::*;
(
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    // Observed sources and processor side
    input wire logic                  sp0TxDone,
    input wire logic [3:0]            inputLine,
    input wire logic                  serviceEnable,
    input wire logic                  grantTake,
    input wire logic                  grantValid,
    input wire epa_event_t            grantEvent,
    input wire epa_group_t            grantGroup,
    input wire epa_level_t            grantLevel,
    input wire logic [33:0]           pendingFlags,
    input wire logic                  lostEvent
);
    localparam logic [33:0] COMM_MASK = 34'h0_0780_0300;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_PEND_SET: assert property (sp0TxDone |=> pendingFlags[9])
        else $error("Transmit event of port 0 not latched");
    AST_COMM_FIRST: assert property (grantValid && grantGroup != `EPA_GRP_COMM
        |-> ($past(pendingFlags) & COMM_MASK) == 34'h0)
        else $error("Lower group offered while a comm event pended");
    AST_LVL_33: assert property (grantValid && grantEvent == 6'h21
        |-> grantGroup == `EPA_GRP_DISC && grantLevel == 5'h17)
        else $error("Counter 5 match offered with wrong rank");
    AST_LVL_22: assert property (grantValid && grantEvent == 6'h16
        |-> grantGroup == `EPA_GRP_TIME && grantLevel == 5'h03)
        else $error("Timer B match offered with wrong rank");
    AST_EN_LOW: assert property (!serviceEnable [*2] |-> !grantValid)
        else $error("Offer shown while service disabled");
    AST_TAKE_GAP: assert property (grantValid && grantTake |=> !grantValid)
        else $error("No dead cycle after a take");
    AST_TAKE_CLR: assert property (grantValid && grantTake && grantEvent == 6'h09
        && !sp0TxDone |=> !pendingFlags[9])
        else $error("Taken event still pending");
    AST_LOST: assert property (sp0TxDone && pendingFlags[9]
        && !(grantValid && grantTake && grantEvent == 6'h09) |=> lostEvent)
        else $error("Repeat arrival not reported");
    AST_RISE0: assert property ($past(rst_n) && $rose(inputLine[0]) |=> pendingFlags[0])
        else $error("Rising edge of input line 0 not latched");
    AST_OFFER: assert property (!grantValid && serviceEnable && $past(serviceEnable)
        && (|pendingFlags) && !$past(grantTake && grantValid) |=> grantValid)
        else $error("Pending event not offered in time");

    // Main scenarios
    COV_TAKE: cover property (grantValid && grantTake);
    COV_LOST: cover property (lostEvent);
    COV_TIME: cover property (grantValid && grantGroup == `EPA_GRP_TIME);
endmodule

bind epa_event_arbiter epa_event_monitor u_mon (.sys_clk, .rst_n, .sp0TxDone, .inputLine,
    .serviceEnable, .grantTake, .grantValid, .grantEvent, .grantGroup, .grantLevel,
    .pendingFlags, .lostEvent);

//--- tb/epa_event_arbiter_test.sv
// Self-checking bench for the event priority arbiter
`timescale 1ns/1ps
module epa_event_arbiter_test
    import epa_pkg::*;
;
    logic        sys_clk;
    logic        rst_n;
    logic [33:0] evIn;
    logic [3:0]  lineLvl;
    logic        serviceEnable;
    logic [3:0]  waitCycles;
    logic        grantTake;
    logic        grantValid;
    epa_event_t  grantEvent;
    epa_group_t  grantGroup;
    epa_level_t  grantLevel;
    logic [33:0] pendingFlags;
    logic        lostEvent;
    epa_event_t  lostEventNum;
    logic        lostSeen;
    logic [12:0] takenQ[$];
    int          mismatches = 0;
    int          num_checks = 0;
    // Expected service order, best rank first
    byte ORD [34] = '{8, 9, 23, 24, 25, 26, 19, 20, 0, 2, 4, 6, 1, 3, 5, 7, 12, 27, 28,
                      13, 14, 15, 16, 17, 18, 32, 29, 30, 31, 33, 10, 11, 21, 22};
    byte AGE [4] = '{23, 8, 26, 24};

    epa_event_arbiter DUT (.sys_clk, .rst_n, .sp0RxChar(evIn[8]), .sp0TxDone(evIn[9]),
        .sp0RxMsg(evIn[23]), .sp1RxMsg(evIn[24]), .sp1RxChar(evIn[25]),
        .sp1TxDone(evIn[26]), .pulseTrainDone(evIn[20:19]), .inputLine(lineLvl),
        .fastCounter0Evt({evIn[28:27], evIn[12]}), .fastCounter1Evt(evIn[15:13]),
        .fastCounter2Evt(evIn[18:16]), .fastCounter3Match(evIn[32]),
        .fastCounter4Evt(evIn[31:29]), .fastCounter5Match(evIn[33]),
        .periodicTick(evIn[11:10]), .delayTimerAMatch(evIn[21]),
        .delayTimerBMatch(evIn[22]), .serviceEnable, .grantTake, .grantValid,
        .grantEvent, .grantGroup, .grantLevel, .pendingFlags, .lostEvent, .lostEventNum);

    epa_proc_model u_proc (.sys_clk, .rst_n, .grantValid, .waitCycles, .grantTake);

    // Clock, 10 ns period
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Log taken grants and lost reports; old values are sampled at the edge
    always @(posedge sys_clk) begin
        if (grantValid === 1'b1 && grantTake === 1'b1)
            takenQ.push_back({grantEvent, grantGroup, grantLevel});
        if (lostEvent === 1'b1)
            lostSeen = 1'b1;
    end

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(input logic [33:0] v);
        @(posedge sys_clk);
        evIn <= v;
        @(posedge sys_clk);
        evIn <= 34'h0;
    endtask

    // Enable service until n grants are taken, then a few idle cycles catch extras
    task automatic drain(input int n);
        int i;
        @(posedge sys_clk);
        serviceEnable <= 1'b1;
        for (i = 0; i < 400 && takenQ.size() < n; i++)
            @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
        serviceEnable <= 1'b0;
        chk("grant count", n, takenQ.size());
    endtask

    // All 34 events pended before service, falling edges one cycle after the rest, served strictly by rank
    task automatic test_order();
        epa_group_t eg;
        epa_level_t el;
        takenQ.delete();
        waitCycles <= 4'h0;
        @(posedge sys_clk);
        lineLvl <= 4'hF;
        evIn    <= 34'h3_FFFF_FF00;
        @(posedge sys_clk);
        lineLvl <= 4'h0;
        evIn    <= 34'h0;
        repeat (3) @(posedge sys_clk);
        chk("pending all", 34'h3_FFFF_FFFF, pendingFlags);
        chk("offer while disabled", 1'b0, grantValid);
        drain(34);
        for (int p = 0; p < 34; p++) begin
            eg = (p < 6) ? 2'h0 : (p < 30) ? 2'h1 : 2'h2;
            el = (p < 6) ? 5'(p / 3) : (p < 30) ? 5'(p - 6) : 5'(p - 30);
            chk("grant", {ORD[p][5:0], eg, el}, takenQ[p]);
        end
        chk("pending after drain", 34'h0, pendingFlags);
        $display("test_order done");
    endtask

    // Equal-rank events served oldest first, with a slow processor
    task automatic test_age();
        takenQ.delete();
        waitCycles <= 4'h3;
        pulse(34'h0_0080_0000);
        pulse(34'h0_0400_0100);
        pulse(34'h0_0100_0000);
        drain(4);
        for (int i = 0; i < 4; i++)
            chk("age order", AGE[i][5:0], takenQ[i][12:7]);
        $display("test_age done");
    endtask

    // Repeat arrival while pending merges and is reported
    task automatic test_lost();
        takenQ.delete();
        lostSeen = 1'b0;
        waitCycles <= 4'h0;
        pulse(34'h0_0000_0200);
        pulse(34'h0_0000_0200);
        repeat (2) @(posedge sys_clk);
        chk("lost pulse", 1'b1, lostSeen);
        chk("lost number", 6'h09, lostEventNum);
        drain(1);
        chk("merged grant", 6'h09, takenQ[0][12:7]);
        $display("test_lost done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #50000;
        mismatches++;
        conclude();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        evIn = 34'h0;
        lineLvl = 4'h0;
        serviceEnable = 1'b0;
        waitCycles = 4'h0;
        lostSeen = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("reset outputs", 34'h0, {grantValid, pendingFlags[32:0]});
        test_order();
        test_age();
        test_lost();
        conclude();
    end
endmodule
